// ==== rtl/pswc_pkg.sv ====
/*
  Shared constants and types of the power-save and wakeup controller:
  register offsets, control field positions, reset values and counts.
  Assumes a 32-bit AXI4-Lite register bus and an 8-pin wake port.
*/
package pswc_pkg;

  // register byte offsets, one aligned word each
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_WAKE_EN   = 8'h04;
  localparam logic [7:0] OFS_WAKE_EDGE = 8'h08;
  localparam logic [7:0] OFS_WAKE_PEND = 8'h0C;
  localparam logic [7:0] OFS_STATUS    = 8'h10;
  localparam logic [7:0] OFS_TIMER     = 8'h14;

  // control register field positions
  localparam int CTRL_HALT_BIT  = 0;
  localparam int CTRL_IDLE_BIT  = 1;
  localparam int CTRL_DLY_BIT   = 2;
  localparam int CTRL_GIE_BIT   = 3;
  localparam int CTRL_PORT_L_IRQ_GLOBAL_ENABLE_BIT  = 4;
  localparam int CTRL_IDLE_TIMER_IRQ_ENABLE_BIT  = 5;
  localparam int CTRL_IDLE_TIMER_PENDING_BIT = 6;

  localparam logic [7:0]  WAKE_RST        = 8'h00;
  localparam logic [15:0] IDLE_TIMER_RST  = 16'h0000;
  localparam logic [15:0] STARTUP_LOAD    = 16'h0100;
  localparam int          TC_DIV_DEFAULT  = 10;
  localparam int          TOGGLE_BIT_DFLT = 12;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    PSWC_RUN,
    PSWC_HALT,
    PSWC_STARTUP,
    PSWC_IDLE
  } pswc_state_t;

  typedef struct packed {
    logic port_g_bit7;             // halt flag
    logic port_g_bit6;             // idle flag
    logic rc_start_delay_select;
    logic global_irq_enable;
    logic port_l_irq_global_enable;
    logic idle_timer_irq_enable;
    logic idle_timer_pending;
  } pswc_ctrl_t;

  localparam pswc_ctrl_t CTRL_RST = '0;

endpackage

// ==== rtl/pswc_top.sv ====
/*
  Power-save controller with halt, idle, startup delay, idle timer and
  multi_input_wake logic on an 8-pin port, registers over AXI4-Lite.
  Assumes i_core_clk is the always-on oscillator domain; stopped clocks
  of the rest of the chip are shown by enable outputs. Pins are
  synchronous to i_core_clk.
*/
`timescale 1ns/1ps

module pswc_top #(
  parameter int HALT_ENABLE = 1,
  parameter int RC_CLOCK    = 0,
  parameter int TC_DIV      = pswc_pkg::TC_DIV_DEFAULT,
  parameter int TOGGLE_BIT  = pswc_pkg::TOGGLE_BIT_DFLT
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_srst,
  input  wire logic        i_reset_pin_n,
  input  wire logic [7:0]  i_lport,
  input  wire logic        i_clock_output_pin,
  input  wire logic        i_clk_monitor_en,
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [7:0]  i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  output logic             o_osc_en,
  output logic             o_chip_clk_en,
  output logic             o_supervisor_inhibit,
  output logic             o_supervisory_fault_output_n,
  output logic             o_tc_tick,
  output logic             o_irq_port_l,
  output logic             o_irq_idle_timer
);

  if (TC_DIV < 2 || TC_DIV > 255) begin : g_bad_div
    $error("pswc_top: TC_DIV out of range");
  end
  if (TOGGLE_BIT < 1 || TOGGLE_BIT > 15) begin : g_bad_bit
    $error("pswc_top: TOGGLE_BIT out of range");
  end

  // the reset pin clears the block like the core reset
  logic rst;
  assign rst = i_srst | ~i_reset_pin_n;

  pswc_pkg::pswc_state_t state_ff;
  pswc_pkg::pswc_ctrl_t  ctrl_ff;
  logic [7:0]  wake_en_ff;
  logic [7:0]  wake_edge_ff;
  logic [7:0]  wake_pend_ff;
  logic [7:0]  lport_prev_ff;
  logic        cko_prev_ff;
  logic [7:0]  div_ff;
  logic [15:0] timer_ff;

  // bus write capture, either channel may come first
  logic        aw_full_ff;
  logic [7:0]  aw_addr_ff;
  logic        w_full_ff;
  logic [31:0] w_data_ff;
  logic [3:0]  w_strb_ff;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == pswc_pkg::OFS_CTRL) || (a == pswc_pkg::OFS_WAKE_EN) ||
             (a == pswc_pkg::OFS_WAKE_EDGE) ||
             (a == pswc_pkg::OFS_WAKE_PEND) ||
             (a == pswc_pkg::OFS_STATUS) || (a == pswc_pkg::OFS_TIMER);
  endfunction

  logic wr_go;
  logic wr_lane0;
  assign wr_go    = aw_full_ff & w_full_ff & ~o_bvalid;
  assign wr_lane0 = wr_go & w_strb_ff[0];

  logic wr_ctrl;
  logic wr_en;
  logic wr_edge;
  logic wr_pend;
  assign wr_ctrl = wr_lane0 && (aw_addr_ff == pswc_pkg::OFS_CTRL);
  assign wr_en   = wr_lane0 && (aw_addr_ff == pswc_pkg::OFS_WAKE_EN);
  assign wr_edge = wr_lane0 && (aw_addr_ff == pswc_pkg::OFS_WAKE_EDGE);
  assign wr_pend = wr_lane0 && (aw_addr_ff == pswc_pkg::OFS_WAKE_PEND);

  // edge detectors run on the always-on clock, even in halt
  logic [7:0] rise;
  logic [7:0] fall;
  logic [7:0] edge_hit;
  assign rise     = i_lport & ~lport_prev_ff;
  assign fall     = ~i_lport & lport_prev_ff;
  assign edge_hit = (wake_edge_ff & fall) | (~wake_edge_ff & rise);

  logic port_wake;
  assign port_wake = |(wake_pend_ff & wake_en_ff);

  logic cko_rise;
  assign cko_rise = (RC_CLOCK != 0) & i_clock_output_pin & ~cko_prev_ff;

  logic tc_tick;
  logic timer_run;
  assign timer_run = (state_ff != pswc_pkg::PSWC_HALT);
  assign tc_tick   = timer_run && (div_ff == 8'(TC_DIV - 1));

  logic toggle;
  logic [15:0] timer_inc;
  assign timer_inc = timer_ff + 16'h0001;
  assign toggle = tc_tick && (state_ff != pswc_pkg::PSWC_STARTUP) &&
                  (timer_inc[TOGGLE_BIT] != timer_ff[TOGGLE_BIT]);

  logic halt_req;
  logic idle_req;
  assign halt_req = wr_ctrl && w_data_ff[pswc_pkg::CTRL_HALT_BIT] &&
                    (HALT_ENABLE != 0) && !port_wake;
  assign idle_req = wr_ctrl && w_data_ff[pswc_pkg::CTRL_IDLE_BIT];

  logic skip_delay;
  assign skip_delay = (RC_CLOCK != 0) && !ctrl_ff.rc_start_delay_select;

  always_ff @(posedge i_core_clk) begin
    if (rst) begin
      lport_prev_ff <= pswc_pkg::WAKE_RST;
      cko_prev_ff   <= 1'b0;
    end else begin
      lport_prev_ff <= i_lport;
      cko_prev_ff   <= i_clock_output_pin;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (rst)
      div_ff <= 8'h00;
    else if (!timer_run)
      div_ff <= div_ff;
    else if (tc_tick)
      div_ff <= 8'h00;
    else
      div_ff <= div_ff + 8'h01;
  end

  // power state machine
  always_ff @(posedge i_core_clk) begin
    if (rst) begin
      state_ff <= pswc_pkg::PSWC_RUN;
    end else begin
      case (state_ff)
        pswc_pkg::PSWC_RUN: begin
          if (halt_req)
            state_ff <= pswc_pkg::PSWC_HALT;
          else if (idle_req)
            state_ff <= pswc_pkg::PSWC_IDLE;
        end
        pswc_pkg::PSWC_HALT: begin
          if (port_wake || cko_rise) begin
            if (skip_delay)
              state_ff <= pswc_pkg::PSWC_RUN;
            else
              state_ff <= pswc_pkg::PSWC_STARTUP;
          end
        end
        pswc_pkg::PSWC_STARTUP: begin
          if (tc_tick && timer_ff == 16'h0001)
            state_ff <= pswc_pkg::PSWC_RUN;
        end
        pswc_pkg::PSWC_IDLE: begin
          if (port_wake || toggle)
            state_ff <= pswc_pkg::PSWC_RUN;
        end
        default: state_ff <= pswc_pkg::PSWC_RUN;
      endcase
    end
  end

  // idle timer: frozen in halt, reloaded for the startup delay
  always_ff @(posedge i_core_clk) begin
    if (rst)
      timer_ff <= pswc_pkg::IDLE_TIMER_RST;
    else if (state_ff == pswc_pkg::PSWC_HALT && (port_wake || cko_rise) &&
             !skip_delay)
      timer_ff <= pswc_pkg::STARTUP_LOAD;
    else if (state_ff == pswc_pkg::PSWC_STARTUP && tc_tick)
      timer_ff <= timer_ff - 16'h0001;
    else if (tc_tick)
      timer_ff <= timer_inc;
  end

  // control flags; hardware set wins over a software clear
  always_ff @(posedge i_core_clk) begin
    if (rst) begin
      ctrl_ff <= pswc_pkg::CTRL_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_ff.rc_start_delay_select <= w_data_ff[pswc_pkg::CTRL_DLY_BIT];
        ctrl_ff.global_irq_enable     <= w_data_ff[pswc_pkg::CTRL_GIE_BIT];
        ctrl_ff.port_l_irq_global_enable <=
          w_data_ff[pswc_pkg::CTRL_PORT_L_IRQ_GLOBAL_ENABLE_BIT];
        ctrl_ff.idle_timer_irq_enable <= w_data_ff[pswc_pkg::CTRL_IDLE_TIMER_IRQ_ENABLE_BIT];
      end
      if (toggle)
        ctrl_ff.idle_timer_pending <= 1'b1;
      else if (wr_ctrl)
        ctrl_ff.idle_timer_pending <= w_data_ff[pswc_pkg::CTRL_IDLE_TIMER_PENDING_BIT];
      // flags read one from mode entry until one cycle after the mode is left
      if (halt_req && state_ff == pswc_pkg::PSWC_RUN)
        ctrl_ff.port_g_bit7 <= 1'b1;
      else if (state_ff != pswc_pkg::PSWC_HALT)
        ctrl_ff.port_g_bit7 <= 1'b0;
      if (idle_req && !halt_req && state_ff == pswc_pkg::PSWC_RUN)
        ctrl_ff.port_g_bit6 <= 1'b1;
      else if (state_ff != pswc_pkg::PSWC_IDLE)
        ctrl_ff.port_g_bit6 <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (rst) begin
      wake_en_ff   <= pswc_pkg::WAKE_RST;
      wake_edge_ff <= pswc_pkg::WAKE_RST;
    end else begin
      if (wr_en)
        wake_en_ff <= w_data_ff[7:0];
      if (wr_edge)
        wake_edge_ff <= w_data_ff[7:0];
    end
  end

  // a new edge in the clearing cycle is kept
  always_ff @(posedge i_core_clk) begin
    if (rst)
      wake_pend_ff <= pswc_pkg::WAKE_RST;
    else if (wr_pend)
      wake_pend_ff <= w_data_ff[7:0] | edge_hit;
    else
      wake_pend_ff <= wake_pend_ff | edge_hit;
  end

  // interrupt requests; the cpu chooses service or resume from these
  always_ff @(posedge i_core_clk) begin
    if (rst) begin
      o_irq_port_l     <= 1'b0;
      o_irq_idle_timer <= 1'b0;
    end else begin
      o_irq_port_l <= ctrl_ff.global_irq_enable &
                      ctrl_ff.port_l_irq_global_enable & port_wake;
      o_irq_idle_timer <= ctrl_ff.global_irq_enable &
                          ctrl_ff.idle_timer_irq_enable &
                          ctrl_ff.idle_timer_pending;
    end
  end

  // chip-side enables
  always_ff @(posedge i_core_clk) begin
    if (rst) begin
      o_osc_en                     <= 1'b1;
      o_chip_clk_en                <= 1'b1;
      o_supervisor_inhibit         <= 1'b0;
      o_supervisory_fault_output_n <= 1'b1;
      o_tc_tick                    <= 1'b0;
    end else begin
      o_osc_en      <= (state_ff != pswc_pkg::PSWC_HALT);
      o_chip_clk_en <= (state_ff == pswc_pkg::PSWC_RUN);
      o_supervisor_inhibit <= (state_ff == pswc_pkg::PSWC_HALT);
      o_supervisory_fault_output_n <=
        !(state_ff == pswc_pkg::PSWC_HALT && i_clk_monitor_en);
      o_tc_tick <= tc_tick;
    end
  end

  // AXI4-Lite write path
  always_ff @(posedge i_core_clk) begin
    if (rst) begin
      aw_full_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_full_ff  <= 1'b0;
      w_data_ff  <= 32'h00000000;
      w_strb_ff  <= 4'h0;
      o_awready  <= 1'b0;
      o_wready   <= 1'b0;
      o_bvalid   <= 1'b0;
      o_bresp    <= pswc_pkg::RESP_OKAY;
    end else begin
      o_awready <= ~aw_full_ff & ~(i_awvalid & o_awready);
      o_wready  <= ~w_full_ff & ~(i_wvalid & o_wready);
      if (i_awvalid && o_awready) begin
        aw_full_ff <= 1'b1;
        aw_addr_ff <= {i_awaddr[7:2], 2'b00};
      end
      if (i_wvalid && o_wready) begin
        w_full_ff <= 1'b1;
        w_data_ff <= i_wdata;
        w_strb_ff <= i_wstrb;
      end
      if (wr_go) begin
        o_bvalid   <= 1'b1;
        o_bresp    <= mapped(aw_addr_ff) ? pswc_pkg::RESP_OKAY
                                         : pswc_pkg::RESP_SLVERR;
        aw_full_ff <= 1'b0;
        w_full_ff  <= 1'b0;
        o_awready  <= 1'b0;
        o_wready   <= 1'b0;
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  // AXI4-Lite read path
  logic [31:0] rd_word;
  logic [7:0]  rd_addr;
  pswc_pkg::pswc_ctrl_t c;
  always_comb begin
    rd_addr = {i_araddr[7:2], 2'b00};
    c       = ctrl_ff;
    rd_word = 32'h00000000;
    case (rd_addr)
      pswc_pkg::OFS_CTRL: begin
        rd_word[pswc_pkg::CTRL_HALT_BIT]  = c.port_g_bit7;
        rd_word[pswc_pkg::CTRL_IDLE_BIT]  = c.port_g_bit6;
        rd_word[pswc_pkg::CTRL_DLY_BIT]   = c.rc_start_delay_select;
        rd_word[pswc_pkg::CTRL_GIE_BIT]   = c.global_irq_enable;
        rd_word[pswc_pkg::CTRL_PORT_L_IRQ_GLOBAL_ENABLE_BIT]  = c.port_l_irq_global_enable;
        rd_word[pswc_pkg::CTRL_IDLE_TIMER_IRQ_ENABLE_BIT]  = c.idle_timer_irq_enable;
        rd_word[pswc_pkg::CTRL_IDLE_TIMER_PENDING_BIT] = c.idle_timer_pending;
      end
      pswc_pkg::OFS_WAKE_EN:   rd_word[7:0] = wake_en_ff;
      pswc_pkg::OFS_WAKE_EDGE: rd_word[7:0] = wake_edge_ff;
      pswc_pkg::OFS_WAKE_PEND: rd_word[7:0] = wake_pend_ff;
      pswc_pkg::OFS_STATUS:    rd_word[1:0] = state_ff;
      pswc_pkg::OFS_TIMER:     rd_word[15:0] = timer_ff;
      default:                 rd_word = 32'h00000000;
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (rst) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h00000000;
      o_rresp   <= pswc_pkg::RESP_OKAY;
    end else begin
      o_arready <= ~o_rvalid & ~(i_arvalid & o_arready);
      if (i_arvalid && o_arready) begin
        o_rvalid  <= 1'b1;
        o_arready <= 1'b0;
        o_rdata   <= rd_word;
        o_rresp   <= mapped(rd_addr) ? pswc_pkg::RESP_OKAY
                                     : pswc_pkg::RESP_SLVERR;
      end else if (o_rvalid && i_rready) begin
        o_rvalid <= 1'b0;
      end
    end
  end

endmodule

// ==== bench/pswc_props.sv ====
/*
  Port checker of the power-save controller, bound to its top.
  Assumes TC_DIV and TOGGLE_BIT are handed on from the bound instance.
*/
`timescale 1ns/1ps
module pswc_props #(
  parameter int TC_DIV     = 10,
  parameter int TOGGLE_BIT = 12
) (
  input wire logic       i_core_clk,
  input wire logic       i_srst,
  input wire logic       i_reset_pin_n,
  input wire logic       i_clk_monitor_en,
  input wire logic       i_bready,
  input wire logic [1:0] o_bresp,
  input wire logic       o_bvalid,
  input wire logic       o_osc_en,
  input wire logic       o_chip_clk_en,
  input wire logic       o_supervisor_inhibit,
  input wire logic       o_supervisory_fault_output_n,
  input wire logic       o_tc_tick
);
  localparam int ST_LO = 256 * TC_DIV - 20;
  localparam int ST_HI = 256 * TC_DIV + 20;
  localparam int ID_MAX = TC_DIV * (2 ** TOGGLE_BIT) + 2 * TC_DIV + 4;
  logic        rst;
  logic [15:0] gap_ff;
  logic [15:0] wcnt_ff;
  logic        seen_ff;
  logic        woke_ff;
  assign rst = i_srst || !i_reset_pin_n;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (rst);
  // starts at one so the next tick lands exactly on TC_DIV
  always_ff @(posedge i_core_clk) begin
    if (rst || o_tc_tick || !o_osc_en) gap_ff <= 16'h0001;
    else gap_ff <= gap_ff + 16'h0001;
  end
  // first tick after a stop has a free phase, so it is not judged
  always_ff @(posedge i_core_clk) begin
    if (rst || !o_osc_en) seen_ff <= 1'b0;
    else if (o_tc_tick) seen_ff <= 1'b1;
  end
  always_ff @(posedge i_core_clk) begin
    if (rst || o_chip_clk_en || !o_osc_en) wcnt_ff <= 16'h0000;
    else wcnt_ff <= wcnt_ff + 16'h0001;
  end
  always_ff @(posedge i_core_clk) begin
    if (rst || o_chip_clk_en) woke_ff <= 1'b0;
    else if (!o_osc_en) woke_ff <= 1'b1;
  end
  property p_halt_clk; !o_osc_en |-> !o_chip_clk_en; endproperty
  a_halt_clk: assert property (p_halt_clk)
    else $error("chip clock on in halt");
  property p_inhibit; o_supervisor_inhibit == !o_osc_en; endproperty
  a_inhibit: assert property (p_inhibit)
    else $error("inhibit out of step with halt");
  property p_fault;
    o_supervisory_fault_output_n ==
      !(o_supervisor_inhibit && $past(i_clk_monitor_en));
  endproperty
  a_fault: assert property (p_fault)
    else $error("fault pin wrong");
  property p_gap; o_tc_tick && seen_ff |-> gap_ff == TC_DIV; endproperty
  a_gap: assert property (p_gap)
    else $error("tick period wrong");
  property p_pulse; $rose(o_tc_tick) |=> !o_tc_tick [*8]; endproperty
  a_pulse: assert property (p_pulse)
    else $error("tick too close");
  property p_start;
    $rose(o_chip_clk_en) && woke_ff |-> wcnt_ff >= ST_LO && wcnt_ff <= ST_HI;
  endproperty
  a_start: assert property (p_start)
    else $error("startup delay wrong");
  property p_idle; !woke_ff |-> wcnt_ff <= ID_MAX; endproperty
  a_idle: assert property (p_idle)
    else $error("idle not left on timer");
  property p_bhold;
    o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp);
  endproperty
  a_bhold: assert property (p_bhold)
    else $error("write response dropped");
endmodule

bind pswc_top pswc_props #(.TC_DIV(TC_DIV), .TOGGLE_BIT(TOGGLE_BIT)) u_props (
  .i_core_clk(i_core_clk), .i_srst(i_srst), .i_reset_pin_n(i_reset_pin_n),
  .i_clk_monitor_en(i_clk_monitor_en), .i_bready(i_bready),
  .o_bresp(o_bresp), .o_bvalid(o_bvalid), .o_osc_en(o_osc_en),
  .o_chip_clk_en(o_chip_clk_en), .o_supervisor_inhibit(o_supervisor_inhibit),
  .o_supervisory_fault_output_n(o_supervisory_fault_output_n),
  .o_tc_tick(o_tc_tick));

// ==== bench/pswc_pins.sv ====
/*
  Pin model around the controller: wake port, reset pin, clock pin.
  Assumes the bench calls its tasks; pins move just after an edge.
*/
`timescale 1ns/1ps
module pswc_pins (
  input  wire logic       i_core_clk,
  output logic      [7:0] o_lport,
  output logic            o_rst_pin_n,
  output logic            o_ck_pin
);
  initial begin
    o_lport     = 8'h00;
    o_rst_pin_n = 1'b1;
    o_ck_pin    = 1'b0;
  end
  task automatic set_pin(input int idx, input logic lvl);
    @(posedge i_core_clk);
    o_lport[idx] <= lvl;
  endtask
  // held for whole edges since the pin reset is sampled synchronously
  task automatic pull_reset(input int n);
    @(posedge i_core_clk);
    o_rst_pin_n <= 1'b0;
    repeat (n) @(posedge i_core_clk);
    o_rst_pin_n <= 1'b1;
  endtask
  task automatic ck_rise;
    @(posedge i_core_clk);
    o_ck_pin <= 1'b1;
  endtask
endmodule

// ==== bench/testbench.sv ====
/*
  Self-checking bench of the power-save controller with a pin model.
  Assumes the register bus answers in every power state.
*/
`timescale 1ns/1ps
module testbench;
  localparam int TCD = 10;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        mon = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, pol;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic        osc, chip, inh, flt_n, tick, irq_l, irq_t, rpin_n, ckpin;
  logic        osc_rc, chip_rc, osc_nh, chip_nh;
  logic [7:0]  lport;
  logic [33:0] rq[$];
  logic [1:0]  bq[$];
  logic [31:0] seed = 32'h0001197E;
  int          n_fail = 0;
  int          compares = 0;
  int          n;

  always #25 clk = ~clk;

  pswc_pins u_pins (.i_core_clk(clk), .o_lport(lport), .o_rst_pin_n(rpin_n),
    .o_ck_pin(ckpin));
  pswc_top #(.TC_DIV(TCD), .TOGGLE_BIT(3)) u_dut (
    .i_core_clk(clk), .i_srst(srst), .i_reset_pin_n(rpin_n),
    .i_lport(lport), .i_clock_output_pin(ckpin), .i_clk_monitor_en(mon),
    .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
    .i_wdata(wdata), .i_wstrb(4'hF), .i_wvalid(wvalid), .o_wready(wready),
    .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
    .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
    .o_osc_en(osc), .o_chip_clk_en(chip), .o_supervisor_inhibit(inh),
    .o_supervisory_fault_output_n(flt_n), .o_tc_tick(tick),
    .o_irq_port_l(irq_l), .o_irq_idle_timer(irq_t));
  // rc variant wakes on the clock pin; the other cannot halt at all
  pswc_top #(.RC_CLOCK(1), .TOGGLE_BIT(3)) u_dut_rc (
    .i_core_clk(clk), .i_srst(srst), .i_reset_pin_n(rpin_n),
    .i_lport(lport), .i_clock_output_pin(ckpin), .i_clk_monitor_en(mon),
    .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(),
    .i_wdata(wdata), .i_wstrb(4'hF), .i_wvalid(wvalid), .o_wready(),
    .o_bresp(), .o_bvalid(), .i_bready(bready),
    .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(),
    .o_rdata(), .o_rresp(), .o_rvalid(), .i_rready(rready),
    .o_osc_en(osc_rc), .o_chip_clk_en(chip_rc), .o_supervisor_inhibit(),
    .o_supervisory_fault_output_n(), .o_tc_tick(),
    .o_irq_port_l(), .o_irq_idle_timer());
  pswc_top #(.HALT_ENABLE(0), .TOGGLE_BIT(3)) u_dut_nh (
    .i_core_clk(clk), .i_srst(srst), .i_reset_pin_n(rpin_n),
    .i_lport(lport), .i_clock_output_pin(ckpin), .i_clk_monitor_en(mon),
    .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(),
    .i_wdata(wdata), .i_wstrb(4'hF), .i_wvalid(wvalid), .o_wready(),
    .o_bresp(), .o_bvalid(), .i_bready(bready),
    .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(),
    .o_rdata(), .o_rresp(), .o_rvalid(), .i_rready(rready),
    .o_osc_en(osc_nh), .o_chip_clk_en(chip_nh), .o_supervisor_inhibit(),
    .o_supervisory_fault_output_n(), .o_tc_tick(),
    .o_irq_port_l(), .o_irq_idle_timer());

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic check(input string nm, input logic [33:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic tmo;
    n_fail++;
    $display("wait ran out at %0t", $time);
    stop_test();
  endtask
  task automatic fin(input string s);
    $display("test %s done", s);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r = 2'h0);
    bq.push_back(r);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (int k = 0; k <= 200; k++) begin
      if (k == 200) tmo();
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid && bready) break;
      // late ready makes the slave hold its response a while
      if (k == 3) bready <= 1'b1;
    end
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r = 2'h0);
    rq.push_back({r, d});
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int k = 0; k <= 200; k++) begin
      if (k == 200) tmo();
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
  endtask
  task automatic wait_hi(input bit sel, input int lim);
    for (n = 0; (sel ? chip : osc) !== 1'b1; n++) begin
      if (n >= lim) tmo();
      @(posedge clk);
    end
  endtask

  always @(posedge clk) begin
    if (rvalid && rready && rq.size() > 0)
      check("read", {rresp, rdata}, rq.pop_front());
    if (bvalid && bready && bq.size() > 0)
      check("bresp", {32'h0, bresp}, {32'h0, bq.pop_front()});
  end

  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 20; i += 4) rd(8'(i), 32'h0);
    rd(8'h18, 32'h0, pswc_pkg::RESP_SLVERR);
    wr(8'h18, 32'hFF, pswc_pkg::RESP_SLVERR);
    for (int i = 4; i < 16; i += 4) begin
      seed = xs(seed);
      wr(8'(i), seed);
      rd(8'(i), {24'h0, seed[7:0]});
      wr(8'(i), 32'h0);
    end
    fin("registers");
    // enable only after edge and pending are settled
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      pol = seed[0];
      wr(pswc_pkg::OFS_WAKE_EDGE, 32'(pol) << i);
      u_pins.set_pin(i, pol);
      repeat (3) @(posedge clk);
      rd(pswc_pkg::OFS_WAKE_PEND, 32'h0);
      u_pins.set_pin(i, !pol);
      u_pins.set_pin(i, 1'b0);
      repeat (3) @(posedge clk);
      rd(pswc_pkg::OFS_WAKE_PEND, 32'h1 << i);
      wr(pswc_pkg::OFS_WAKE_EN, 32'h1 << i);
      wr(pswc_pkg::OFS_CTRL, 32'h18);
      repeat (2) @(posedge clk);
      check("irq_l", irq_l, 1'b1);
      wr(pswc_pkg::OFS_CTRL, 32'h10);
      repeat (2) @(posedge clk);
      check("irq_l", irq_l, 1'b0);
      wr(pswc_pkg::OFS_CTRL, 32'h0);
      if (i < 7) wr(pswc_pkg::OFS_WAKE_EN, 32'h0);
      if (i < 7) wr(pswc_pkg::OFS_WAKE_PEND, 32'h0);
    end
    fin("edges");
    wr(pswc_pkg::OFS_CTRL, 32'h1);
    repeat (3) @(posedge clk);
    check("osc", osc, 1'b1);
    rd(pswc_pkg::OFS_STATUS, 32'h0);
    wr(pswc_pkg::OFS_WAKE_EDGE, 32'h0);
    wr(pswc_pkg::OFS_WAKE_PEND, 32'h0);
    wr(pswc_pkg::OFS_WAKE_EN, 32'h1);
    fin("refuse");
    mon <= 1'b1;
    // delay bit set: only the rc variant heeds it and the clock pin
    wr(pswc_pkg::OFS_CTRL, 32'h5);
    u_pins.ck_rise();
    repeat (6) @(posedge clk);
    check("halt", {osc, chip, inh, flt_n, tick}, 5'h04);
    check("rc_wake", {osc_rc, chip_rc}, 2'h2);
    check("no_halt", {osc_nh, chip_nh}, 2'h3);
    u_pins.set_pin(0, 1'b1);
    wait_hi(0, 20);
    wait_hi(1, 4000);
    check("startup", n >= 255 * TCD && n <= 257 * TCD, 1'b1);
    rd(pswc_pkg::OFS_STATUS, 32'h0);
    rd(pswc_pkg::OFS_WAKE_PEND, 32'h1);
    rd(pswc_pkg::OFS_WAKE_EN, 32'h1);
    u_pins.set_pin(0, 1'b0);
    wr(pswc_pkg::OFS_WAKE_PEND, 32'h0);
    wr(pswc_pkg::OFS_CTRL, 32'h1);
    repeat (3) @(posedge clk);
    u_pins.pull_reset(2);
    repeat (2) @(posedge clk);
    check("osc", osc, 1'b1);
    rd(pswc_pkg::OFS_WAKE_EN, 32'h0);
    fin("halt");
    wr(pswc_pkg::OFS_CTRL, 32'h08);
    wr(pswc_pkg::OFS_CTRL, 32'h2A);
    repeat (2) @(posedge clk);
    check("idle", {osc, chip}, 2'h2);
    wait_hi(1, 16 * TCD + 20);
    repeat (2) @(posedge clk);
    check("irq_t", irq_t, 1'b1);
    wr(pswc_pkg::OFS_CTRL, 32'h08);
    repeat (2) @(posedge clk);
    check("irq_t", irq_t, 1'b0);
    fin("idle");
    stop_test();
  end
endmodule
